// ### peg_top.v
`timescale 1ns/1ps
`include "peg_regs.vh"

module peg_top (
    // clock and reset
    input  wire        ref_clk,
    input  wire        sys_rst,
    // ahb-lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output wire        hreadyout,
    output wire        hresp,
    // counter events, one bit per channel
    input  wire [2:0]  cnt_zero,
    input  wire [2:0]  cnt_load,
    input  wire [2:0]  cmp_a_match,
    input  wire [2:0]  cmp_b_match,
    input  wire [2:0]  cmp_c_match,
    input  wire [2:0]  cnt_up,
    // raw outputs to the dead-band stage
    output wire [2:0]  raw_a,
    output wire [2:0]  raw_b
);

    reg  [15:0] action_ctrl [0:5];
    wire        rd_take;
    wire [2:0]  rd_idx;
    wire        wr_en;
    wire [2:0]  wr_idx;
    reg  [15:0] next_rdata;
    integer     i;

    peg_ahb_slave u_bus (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .rd_take   (rd_take),
        .rd_idx    (rd_idx),
        .wr_en     (wr_en),
        .wr_idx    (wr_idx)
    );

    // only the low half is stored; hsize is ignored, every write is a word
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            for (i = 0; i < `PEG_NUM_REGS; i = i + 1) begin
                action_ctrl[i] <= `PEG_CTRL_RESET;
            end
        end else if (wr_en && wr_idx != `PEG_IDX_NONE) begin
            action_ctrl[wr_idx] <= hwdata[15:0];
        end
    end

    // forward a write still in its data phase so back-to-back read sees it
    always @* begin
        next_rdata = 16'h0000;
        if (rd_idx != `PEG_IDX_NONE) begin
            if (wr_en && wr_idx == rd_idx) begin
                next_rdata = hwdata[15:0];
            end else begin
                next_rdata = action_ctrl[rd_idx];
            end
        end
    end

    always @(posedge ref_clk) begin
        if (sys_rst) begin
            hrdata <= 32'h00000000;
        end else if (rd_take) begin
            hrdata <= {16'h0000, next_rdata};
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < 3; ch = ch + 1) begin : g_ch
            peg_action_unit u_a (
                .ref_clk     (ref_clk),
                .sys_rst     (sys_rst),
                .action_ctrl (action_ctrl[2*ch]),
                .cnt_zero    (cnt_zero[ch]),
                .cnt_load    (cnt_load[ch]),
                .cmp_a_match (cmp_a_match[ch]),
                .cmp_b_match (cmp_b_match[ch]),
                .cmp_c_match (cmp_c_match[ch]),
                .cnt_up      (cnt_up[ch]),
                .raw_out     (raw_a[ch])
            );
            peg_action_unit u_b (
                .ref_clk     (ref_clk),
                .sys_rst     (sys_rst),
                .action_ctrl (action_ctrl[2*ch+1]),
                .cnt_zero    (cnt_zero[ch]),
                .cnt_load    (cnt_load[ch]),
                .cmp_a_match (cmp_a_match[ch]),
                .cmp_b_match (cmp_b_match[ch]),
                .cmp_c_match (cmp_c_match[ch]),
                .cnt_up      (cnt_up[ch]),
                .raw_out     (raw_b[ch])
            );
        end
    endgenerate

endmodule

// ### peg_regs.vh
`ifndef PEG_REGS_VH
`define PEG_REGS_VH

// register byte offsets
`define PEG_OFS_PWM0_A      8'h6c
`define PEG_OFS_PWM0_B      8'h70
`define PEG_OFS_PWM1_A      8'hac
`define PEG_OFS_PWM1_B      8'hb0
`define PEG_OFS_PWM2_A      8'hec
`define PEG_OFS_PWM2_B      8'hf0

// register indices; PEG_IDX_NONE marks an unmapped address
`define PEG_IDX_W           3
`define PEG_IDX_NONE        3'h7
`define PEG_NUM_REGS        6

// action control register layout
`define PEG_CTRL_W          16
`define PEG_CTRL_RESET      16'h0000
`define PEG_ZERO_LSB        0
`define PEG_LOAD_LSB        2
`define PEG_CMPA_UP_LSB     4
`define PEG_CMPA_DN_LSB     6
`define PEG_CMPB_UP_LSB     8
`define PEG_CMPB_DN_LSB     10
`define PEG_CMPC_UP_LSB     12
`define PEG_CMPC_DN_LSB     14

// action codes
`define PEG_ACT_NONE        2'h0
`define PEG_ACT_TOGGLE      2'h1
`define PEG_ACT_LOW         2'h2
`define PEG_ACT_HIGH        2'h3

// ahb-lite
`define PEG_HTRANS_NONSEQ   2'h2
`define PEG_HRESP_OKAY      1'h0

`endif

// ### peg_action_unit.v
`timescale 1ns/1ps
`include "peg_regs.vh"

module peg_action_unit (
    // clock and reset
    input  wire        ref_clk,
    input  wire        sys_rst,
    // action fields for this output
    input  wire [15:0] action_ctrl,
    // counter events of the owning channel
    input  wire        cnt_zero,
    input  wire        cnt_load,
    input  wire        cmp_a_match,
    input  wire        cmp_b_match,
    input  wire        cmp_c_match,
    input  wire        cnt_up,
    // raw level
    output reg         raw_out
);

    function [1:0] field;
        input [15:0] ctrl;
        input integer lsb;
        begin
            field = ctrl[lsb +: 2];
        end
    endfunction

    reg [1:0] next_action;
    reg       next_raw;

    // one event wins per cycle; comparator c ranks below a and b
    always @* begin
        next_action = `PEG_ACT_NONE;
        if (cnt_zero) begin
            next_action = field(action_ctrl, `PEG_ZERO_LSB);
        end else if (cnt_load) begin
            next_action = field(action_ctrl, `PEG_LOAD_LSB);
        end else if (cmp_a_match) begin
            // direction picks the up or down field
            next_action = cnt_up ? field(action_ctrl, `PEG_CMPA_UP_LSB)
                                 : field(action_ctrl, `PEG_CMPA_DN_LSB);
        end else if (cmp_b_match) begin
            next_action = cnt_up ? field(action_ctrl, `PEG_CMPB_UP_LSB)
                                 : field(action_ctrl, `PEG_CMPB_DN_LSB);
        end else if (cmp_c_match) begin
            next_action = cnt_up ? field(action_ctrl, `PEG_CMPC_UP_LSB)
                                 : field(action_ctrl, `PEG_CMPC_DN_LSB);
        end
    end

    always @* begin
        case (next_action)
            `PEG_ACT_TOGGLE: next_raw = ~raw_out;
            `PEG_ACT_LOW:    next_raw = 1'b0;
            `PEG_ACT_HIGH:   next_raw = 1'b1;
            default:         next_raw = raw_out;
        endcase
    end

    always @(posedge ref_clk) begin
        if (sys_rst) begin
            raw_out <= 1'b0;
        end else begin
            raw_out <= next_raw;
        end
    end

endmodule

// ### peg_ahb_slave.v
`timescale 1ns/1ps
`include "peg_regs.vh"

module peg_ahb_slave (
    // clock and reset
    input  wire        ref_clk,
    input  wire        sys_rst,
    // ahb-lite address phase
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire        hready,
    // ahb-lite response
    output reg         hreadyout,
    output reg         hresp,
    // register file side
    output wire        rd_take,
    output wire [2:0]  rd_idx,
    output wire        wr_en,
    output wire [2:0]  wr_idx
);

    function [2:0] decode;
        input [31:0] addr;
        begin
            if (addr[31:8] != 24'h000000) begin
                decode = `PEG_IDX_NONE;
            end else begin
                case (addr[7:0])
                    `PEG_OFS_PWM0_A: decode = 3'h0;
                    `PEG_OFS_PWM0_B: decode = 3'h1;
                    `PEG_OFS_PWM1_A: decode = 3'h2;
                    `PEG_OFS_PWM1_B: decode = 3'h3;
                    `PEG_OFS_PWM2_A: decode = 3'h4;
                    `PEG_OFS_PWM2_B: decode = 3'h5;
                    default:         decode = `PEG_IDX_NONE;
                endcase
            end
        end
    endfunction

    reg        wr_pend;
    reg  [2:0] wr_addr_idx;
    wire       take;

    // htrans[1] covers both nonseq and seq
    assign take    = hsel & hready & htrans[1];
    assign rd_take = take & ~hwrite;
    assign rd_idx  = decode(haddr);
    assign wr_en   = wr_pend;
    assign wr_idx  = wr_addr_idx;

    always @(posedge ref_clk) begin
        if (sys_rst) begin
            wr_pend     <= 1'b0;
            wr_addr_idx <= `PEG_IDX_NONE;
            hreadyout   <= 1'b0;
            hresp       <= `PEG_HRESP_OKAY;
        end else begin
            // zero wait states, every access answers okay
            hreadyout   <= 1'b1;
            hresp       <= `PEG_HRESP_OKAY;
            wr_pend     <= take & hwrite;
            wr_addr_idx <= decode(haddr);
        end
    end

endmodule

// ### peg_top_monitor.sv
`timescale 1ns/1ps
module peg_mon (
    // clock and bus
    input logic        ref_clk,
    input logic        sys_rst,
    input logic        hsel,
    input logic [31:0] haddr,
    input logic [1:0]  htrans,
    input logic        hwrite,
    input logic [31:0] hwdata,
    input logic        hready,
    input logic [31:0] hrdata,
    // events and raw levels
    input logic [2:0]  cnt_zero,
    input logic [2:0]  cnt_load,
    input logic [2:0]  cmp_a_match,
    input logic [2:0]  cmp_b_match,
    input logic [2:0]  cmp_c_match,
    input logic [2:0]  cnt_up,
    input logic [2:0]  raw_a,
    input logic [2:0]  raw_b
);
    // only channel 0 output a is mirrored, to keep the checker small
    logic [15:0] m;
    logic        wp;
    logic [1:0]  w;
    logic [2:0]  ev;
    assign ev = cnt_zero | cnt_load | cmp_a_match | cmp_b_match | cmp_c_match;
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            m <= 16'h0000;
            wp <= 1'b0;
        end else begin
            if (wp)
                m <= hwdata[15:0];
            if (hready)
                wp <= hsel & htrans[1] & hwrite & (haddr == 32'h6c);
        end
    end
    always @* begin
        if (cnt_zero[0])         w = m[1:0];
        else if (cnt_load[0])    w = m[3:2];
        else if (cmp_a_match[0]) w = cnt_up[0] ? m[5:4] : m[7:6];
        else if (cmp_b_match[0]) w = cnt_up[0] ? m[9:8] : m[11:10];
        else if (cmp_c_match[0]) w = cnt_up[0] ? m[13:12] : m[15:14];
        else                     w = 2'h0;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    hold_idle_a:
    assert property (w == 2'h0 |=> $stable(raw_a[0])) else $error("idle moved");
    toggle_act_a:
    assert property (w == 2'h1 |=> raw_a[0] != $past(raw_a[0])) else $error("no toggle");
    drive_low_a:
    assert property (w == 2'h2 |=> !raw_a[0]) else $error("not low");
    drive_high_a:
    assert property (w == 2'h3 |=> raw_a[0]) else $error("not high");
    quiet_hold_a:
    assert property ((((raw_a ^ $past(raw_a)) | (raw_b ^ $past(raw_b))) & ~$past(ev)) == 3'h0)
        else $error("moved without event");
    upper_zero_a:
    assert property (hrdata[31:16] == 16'h0000) else $error("upper bits set");
    zero_first_a:
    assert property (cnt_zero[0] && m[1:0] == 2'h2 |=> !raw_a[0]) else $error("zero lost");
    cmp_a_first_a:
    assert property (!cnt_zero[0] && !cnt_load[0] && cmp_a_match[0] && cmp_b_match[0]
        && cnt_up[0] && m[5:4] == 2'h3 |=> raw_a[0]) else $error("cmp a lost");
endmodule
bind peg_top peg_mon i_mon (.ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .cnt_zero(cnt_zero), .cnt_load(cnt_load), .cmp_a_match(cmp_a_match),
    .cmp_b_match(cmp_b_match), .cmp_c_match(cmp_c_match), .cnt_up(cnt_up), .raw_a(raw_a),
    .raw_b(raw_b));

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
    logic        ref_clk = 1'b0, sys_rst = 1'b1, hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rdat, a;
    logic [2:0]  cnt_zero = 3'h0, cnt_load = 3'h0, cmp_a_match = 3'h0;
    logic [2:0]  cmp_b_match = 3'h0, cmp_c_match = 3'h0, cnt_up = 3'h0;
    logic [4:0]  e;
    wire  [31:0] hrdata;
    wire         hreadyout, hresp;
    wire  [2:0]  raw_a, raw_b;
    integer      num_errors = 0, checked = 0, k, c, n;
    always #2.5 ref_clk = ~ref_clk;
    peg_top i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cnt_zero(cnt_zero),
        .cnt_load(cnt_load), .cmp_a_match(cmp_a_match), .cmp_b_match(cmp_b_match),
        .cmp_c_match(cmp_c_match), .cnt_up(cnt_up), .raw_a(raw_a), .raw_b(raw_b));
    task finish_test;
        begin
            $display("checks %0d errors %0d", checked, num_errors);
            if (num_errors == 0 && checked > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    task chk(input [31:0] g, input [31:0] x);
        begin
            checked = checked + 1;
            if (g !== x) begin
                num_errors = num_errors + 1;
                $display("MISMATCH %0t got %h exp %h", $time, g, x);
            end
        end
    endtask
    // sampled mid-cycle so the ready flop never races the edge
    task wt;
        integer t;
        begin
            t = 0;
            @(negedge ref_clk);
            while (hreadyout !== 1'b1) begin
                t = t + 1;
                if (t > 40) begin
                    num_errors = num_errors + 1;
                    finish_test;
                end
                @(negedge ref_clk);
            end
            rdat = hrdata;
            @(posedge ref_clk);
        end
    endtask
    task xfer(input w, input [31:0] ad, input [31:0] d);
        begin
            @(posedge ref_clk);
            haddr <= ad;
            hwrite <= w;
            htrans <= 2'h2;
            wt;
            htrans <= 2'h0;
            hwdata <= d;
            wt;
        end
    endtask
    task rd(input [31:0] ad, input [31:0] x);
        begin
            xfer(1'b0, ad, 32'h0);
            chk(rdat, x);
            chk({31'h0, hresp}, 32'h0);
        end
    endtask
    task ev(input integer ch, input [4:0] ev_on, input up, input s, input x);
        integer i;
        logic [14:0] v;
        begin
            v = 15'h0;
            for (i = 0; i < 5; i = i + 1)
                v[3 * i + ch] = ev_on[i];
            @(posedge ref_clk);
            {cmp_c_match, cmp_b_match, cmp_a_match, cnt_load, cnt_zero} <= v;
            cnt_up <= {3{up}};
            @(posedge ref_clk);
            {cmp_c_match, cmp_b_match, cmp_a_match, cnt_load, cnt_zero} <= 15'h0;
            @(negedge ref_clk);
            chk({31'h0, s ? raw_b[ch] : raw_a[ch]}, {31'h0, x});
        end
    endtask
    initial begin
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        for (k = 0; k < 6; k = k + 1)
            rd(32'h6c + 32'h40 * (k / 2) + 32'h4 * (k % 2), 32'h0);
        rd(32'h74, 32'h0);
        xfer(1'b1, 32'hb0, 32'hffff_5a5a);
        rd(32'hb0, 32'h5a5a);
        $display("register test done");
        for (k = 0; k < 32; k = k + 1) begin
            c = 3 - k % 4;
            n = k / 4;
            a = 32'h6c + 32'h40 * (n % 3) + 32'h4 * n[1];
            e = (n < 2) ? 5'h1 << n : 5'h1 << (n / 2 + 1);
            xfer(1'b1, a, c << (2 * n));
            ev(n % 3, e, !n[0], n[1], c != 2);
        end
        $display("field test done");
        xfer(1'b1, 32'h6c, 32'h0232);
        ev(0, 5'h0c, 1'b1, 1'b0, 1'b1);
        ev(0, 5'h0a, 1'b1, 1'b0, 1'b1);
        ev(0, 5'h05, 1'b1, 1'b0, 1'b0);
        ev(0, 5'h04, 1'b0, 1'b0, 1'b0);
        ev(0, 5'h04, 1'b1, 1'b0, 1'b1);
        $display("priority test done");
        finish_test;
    end
endmodule
